// >>> hdl/sbtw_top.sv
/*
  Timing registers and watchdog refresh core, written over the serial link.
  Assumes mode change requests come from same-clock mode logic and that the
  parity enable input is a stable configuration level on the core clock.
*/
// Behaviour
// - address 01010 writes window and watchdog codes
// - over-current window 3 or 4 ms, doubled
// - normal watchdog base 2.5-4 ms, doubled
// - power-on reset loads default timing codes
// - address 01011 writes cyclic sense, interrupt
// - cyclic sense 3 or 4 ms, doubled
// - cyclic interrupt 6 or 8 ms, 258 exception
// - address 01100 writes low-power/flash, wake-up
// - low-power watchdog 12 or 16 ms, doubled
// - flash watchdog 48 or 256 ms, doubled
// - forced wake-up 48 or 64 ms, 258 exception
// - refresh register address 01101, data zero
// - command 5a00 restarts the watchdog period
// - refresh in initialization enters normal mode
// - refresh in normal-request enters normal mode
// - parity bit checked when enabled, else zero
`timescale 1ns/1ps
module sbtw_top
  import sbtw_pkg::*;
#(
  parameter int TICK_CYC_P     = TICK_CYC,
  parameter int RST_HOLD_CYC_P = RST_HOLD_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_n_o,
  input  wire logic        parity_en_i,
  input  wire logic        enter_nreq_i,
  input  wire logic        enter_lowpower_i,
  input  wire logic        enter_flash_i,
  output logic [2:0]       mode_o,
  output logic             wd_reset_n_o,
  output logic             frame_err_o,
  output sbtw_per_t        oc_window_o,
  output sbtw_per_t        wd_period_o,
  output sbtw_per_t        cyc_sense_o,
  output sbtw_per_t        cyc_int_o,
  output sbtw_per_t        fwu_o,
  output logic [7:0]       first_timing_register_o,
  output logic [7:0]       second_timing_register_o,
  output logic [7:0]       third_timing_register_o
);

  localparam int RW = $clog2(RST_HOLD_CYC_P + 1);

  if (RST_HOLD_CYC_P < 1)
  begin : g_bad_hold
    $error("RST_HOLD_CYC_P must be at least 1");
  end

  typedef struct packed {
    logic [2:0]  sync;
    logic [7:0]  tim1;
    logic [7:0]  tim2;
    logic [7:0]  tim3;
    sbtw_mode_t  mode;
    logic [RW-1:0] hold;
    logic        rst_n_out;
    logic        err;
    sbtw_per_t   oc;
    sbtw_per_t   wdp;
    sbtw_per_t   csn;
    sbtw_per_t   cin;
    sbtw_per_t   forced_wakeup_period;
  } sbtw_core_t;

  sbtw_core_t  r;
  sbtw_core_t  next_r;
  sbtw_link_if link ();

  logic        stb;
  logic [15:0] word;
  logic        parity_ok;
  logic        wr;
  logic        refresh;
  logic        restart;
  logic        expire;
  logic [4:0]  addr;
  logic [7:0]  data;
  sbtw_per_t   lp_per;
  sbtw_per_t   fl_per;

  sbtw_spi_rx u_rx (
    .sclk_i      (sclk_i),
    .rst_n_i     (rst_n_i),
    .cs_n_i      (cs_n_i),
    .mosi_i      (mosi_i),
    .miso_o      (miso_o),
    .miso_oe_n_o (miso_oe_n_o),
    .link        (link.rx)
  );

  // Word is stable here: it was written with the toggle, two or more core edges before stb
  assign stb  = r.sync[1] ^ r.sync[2];
  assign word = link.word;
  assign addr = word[ADDR_MSB:ADDR_LSB];
  assign data = word[7:0];

  // Even parity over the whole frame when checking is on; else bit must be zero
  assign parity_ok = parity_en_i ? ~^word : ~word[PAR_BIT];
  assign wr        = stb && (word[CMD_MSB:CMD_LSB] == CMD_WRITE) && parity_ok;
  // Refresh needs the exact command, so a non-zero data byte is refused
  assign refresh   = wr && (word == REFRESH_CMD);

  assign lp_per = sbtw_dbl(r.tim3[7] ? 10'd32 : 10'd24, r.tim3[6:4]);
  assign fl_per = sbtw_dbl(r.tim3[7] ? 10'd512 : 10'd96, r.tim3[6:4]);

  always_comb
  begin
    next_r      = r;
    next_r.sync = {r.sync[1:0], link.tgl};
    next_r.err  = stb && !(parity_ok && (addr != ADDR_REFRESH || refresh));
    restart     = refresh || !r.rst_n_out;

    if (wr)
    begin
      unique case (addr)
        ADDR_TIM1: next_r.tim1 = data;
        ADDR_TIM2: next_r.tim2 = data;
        ADDR_TIM3: next_r.tim3 = data;
        default:   ;
      endcase
    end

    if (expire)
    begin
      next_r.rst_n_out = 1'b0;
      next_r.hold      = RW'(RST_HOLD_CYC_P - 1);
      next_r.mode      = ST_NREQ;
    end
    else if (!r.rst_n_out)
    begin
      if (r.hold == '0)
        next_r.rst_n_out = 1'b1;
      else
        next_r.hold = r.hold - RW'(1);
    end
    else if (enter_nreq_i)
    begin
      next_r.mode = ST_NREQ;
    end
    else if (enter_lowpower_i)
    begin
      next_r.mode = ST_LOWPOWER;
    end
    else if (enter_flash_i)
    begin
      next_r.mode = ST_FLASH;
    end
    else if (refresh)
    begin
      unique case (r.mode)
        ST_INIT:     next_r.mode = ST_NORMAL;
        ST_NREQ:     next_r.mode = ST_NORMAL;
        ST_NORMAL:   ;
        ST_LOWPOWER: ;
        ST_FLASH:    ;
      endcase
    end
    // A new mode starts a fresh period at its own length
    if (next_r.mode != r.mode)
      restart = 1'b1;

    next_r.oc  = sbtw_dbl(r.tim1[7] ? 10'd8 : 10'd6, {1'b0, r.tim1[6:5]});
    next_r.csn = sbtw_dbl(r.tim2[7] ? 10'd8 : 10'd6, r.tim2[6:4]);
    if (r.tim2[3:0] == CYC_INT_ODD_CODE)
      next_r.cin = ODD_HALVES;
    else
      next_r.cin = sbtw_dbl(r.tim2[3] ? 10'd16 : 10'd12, r.tim2[2:0]);
    if (r.tim3[3:0] == FWU_ODD_CODE)
      next_r.forced_wakeup_period = ODD_HALVES;
    else
      next_r.forced_wakeup_period = sbtw_dbl(r.tim3[3] ? 10'd128 : 10'd96, r.tim3[2:0]);

    unique case (r.mode)
      ST_INIT,
      ST_NREQ,
      ST_NORMAL:   next_r.wdp = sbtw_dbl(10'(5 + r.tim1[4:3]), r.tim1[2:0]);
      ST_LOWPOWER: next_r.wdp = lp_per;
      ST_FLASH:    next_r.wdp = fl_per;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r           <= '0;
      r.tim1      <= TIM1_RST;
      r.tim2      <= TIM2_RST;
      r.tim3      <= TIM3_RST;
      r.mode      <= ST_INIT;
      r.rst_n_out <= 1'b1;
      r.oc        <= sbtw_per_t'(6);
      r.wdp       <= sbtw_per_t'(512);
      r.csn       <= sbtw_per_t'(6);
      r.cin       <= sbtw_per_t'(12);
      r.forced_wakeup_period       <= sbtw_per_t'(96);
    end
    else
    begin
      r <= next_r;
    end
  end

  // Host keeps refreshing inside wd_period_o; the period in use is the registered one
  sbtw_wd_timer #(
    .TICK_CYC_P (TICK_CYC_P)
  ) u_wdt (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .restart_i (restart),
    .period_i  (r.wdp),
    .expire_o  (expire)
  );

  assign mode_o                   = r.mode;
  assign wd_reset_n_o             = r.rst_n_out;
  assign frame_err_o              = r.err;
  assign oc_window_o              = r.oc;
  assign wd_period_o              = r.wdp;
  assign cyc_sense_o              = r.csn;
  assign cyc_int_o                = r.cin;
  assign fwu_o                    = r.forced_wakeup_period;
  assign first_timing_register_o  = r.tim1;
  assign second_timing_register_o = r.tim2;
  assign third_timing_register_o  = r.tim3;

  property p_tim1_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr && addr == ADDR_TIM1) |=> (r.tim1 == $past(data));
  endproperty
  a_tim1_write: assert property (p_tim1_write)
    else $error("first timing register not written");

  property p_oc_top;
    @(posedge clk_i) disable iff (!rst_n_i)
    (r.tim1[7:5] == 3'h7) ##1 (r.tim1[7:5] == 3'h7) |-> (oc_window_o == sbtw_per_t'(64));
  endproperty
  a_oc_top: assert property (p_oc_top)
    else $error("over-current window not 32 ms");

  property p_wd_normal;
    @(posedge clk_i) disable iff (!rst_n_i)
    (r.mode == ST_NORMAL && r.tim1[4:0] == 5'h1e) |=> (wd_period_o == sbtw_per_t'(512));
  endproperty
  a_wd_normal: assert property (p_wd_normal)
    else $error("normal watchdog not 256 ms");

  property p_default;
    @(posedge clk_i) $rose(rst_n_i) |-> (r.tim1 == TIM1_RST) && (r.tim3 == TIM3_RST);
  endproperty
  a_default: assert property (p_default)
    else $error("timing defaults wrong after reset");

  property p_tim2_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr && addr == ADDR_TIM2) |=> (r.tim2 == $past(data)) ##1 (cyc_sense_o != '0);
  endproperty
  a_tim2_write: assert property (p_tim2_write)
    else $error("second timing register not written");

  property p_cyc_sense;
    @(posedge clk_i) disable iff (!rst_n_i)
    (r.tim2[7:4] == 4'hf) |=> (cyc_sense_o == sbtw_per_t'(1024));
  endproperty
  a_cyc_sense: assert property (p_cyc_sense)
    else $error("cyclic sense not 512 ms");

  property p_cyc_int;
    @(posedge clk_i) disable iff (!rst_n_i)
    (r.tim2[3:0] == 4'hd) |=> (cyc_int_o == sbtw_per_t'(516));
  endproperty
  a_cyc_int: assert property (p_cyc_int)
    else $error("cyclic interrupt not 258 ms");

  property p_lp_wd;
    @(posedge clk_i) disable iff (!rst_n_i)
    (r.mode == ST_LOWPOWER && r.tim3[7:4] == 4'h7) |=> (wd_period_o == sbtw_per_t'(3072));
  endproperty
  a_lp_wd: assert property (p_lp_wd)
    else $error("low-power watchdog not 1536 ms");

  property p_flash_wd;
    @(posedge clk_i) disable iff (!rst_n_i)
    (r.mode == ST_FLASH && r.tim3[7:4] == 4'hf) |=> (wd_period_o == sbtw_per_t'(65536));
  endproperty
  a_flash_wd: assert property (p_flash_wd)
    else $error("flash watchdog not 32768 ms");

  property p_fwu;
    @(posedge clk_i) disable iff (!rst_n_i)
    (r.tim3[3:0] == 4'ha) |=> (fwu_o == sbtw_per_t'(516));
  endproperty
  a_fwu: assert property (p_fwu)
    else $error("forced wake-up not 258 ms");

  property p_init_to_normal;
    @(posedge clk_i) disable iff (!rst_n_i)
    (refresh && r.mode == ST_INIT && r.rst_n_out && !expire
      && !enter_nreq_i && !enter_lowpower_i && !enter_flash_i) |=> (r.mode == ST_NORMAL);
  endproperty
  a_init_to_normal: assert property (p_init_to_normal)
    else $error("refresh did not leave initialization");

  property p_nreq_to_normal;
    @(posedge clk_i) disable iff (!rst_n_i)
    (refresh && r.mode == ST_NREQ && r.rst_n_out && !expire
      && !enter_nreq_i && !enter_lowpower_i && !enter_flash_i) |=> (r.mode == ST_NORMAL);
  endproperty
  a_nreq_to_normal: assert property (p_nreq_to_normal)
    else $error("refresh did not leave normal-request");

  property p_parity;
    @(posedge clk_i) disable iff (!rst_n_i)
    (stb && parity_en_i && ^word) |=> frame_err_o && $stable(r.tim1) && $stable(r.tim2);
  endproperty
  a_parity: assert property (p_parity)
    else $error("bad parity frame accepted");

  property p_wd_fail;
    @(posedge clk_i) disable iff (!rst_n_i)
    expire |=> !wd_reset_n_o && (r.mode == ST_NREQ);
  endproperty
  a_wd_fail: assert property (p_wd_fail)
    else $error("watchdog expiry did not assert reset");

endmodule

// >>> hdl/sbtw_pkg.sv
/*
  Shared constants, types and period decoding for the timing and watchdog block.
  Assumes a 50 MHz core clock and 16-bit write frames on the serial link.
*/
package sbtw_pkg;

  localparam int CLK_PERIOD_NS = 20;
  // Periods are kept in half milliseconds so that 2.5 ms stays exact
  localparam int TICK_NS       = 500_000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HOLD_NS   = 1_000_000;
  localparam int RST_HOLD_CYC  = RST_HOLD_NS / CLK_PERIOD_NS;

  localparam int FRAME_BITS = 16;
  localparam int PER_W      = 17;
  localparam int CMD_MSB    = 15;
  localparam int CMD_LSB    = 14;
  localparam int ADDR_MSB   = 13;
  localparam int ADDR_LSB   = 9;
  localparam int PAR_BIT    = 8;

  localparam logic [1:0]  CMD_WRITE    = 2'h1;
  localparam logic [4:0]  ADDR_TIM1    = 5'h0a;
  localparam logic [4:0]  ADDR_TIM2    = 5'h0b;
  localparam logic [4:0]  ADDR_TIM3    = 5'h0c;
  localparam logic [4:0]  ADDR_REFRESH = 5'h0d;
  localparam logic [15:0] REFRESH_CMD  = 16'h5a00;

  localparam logic [7:0] TIM1_RST = 8'h1e;
  localparam logic [7:0] TIM2_RST = 8'h00;
  localparam logic [7:0] TIM3_RST = 8'h00;

  // Two table entries break the doubling pattern (258 ms instead of 256 ms)
  localparam logic [3:0]       CYC_INT_ODD_CODE = 4'hd;
  localparam logic [3:0]       FWU_ODD_CODE     = 4'ha;
  localparam logic [PER_W-1:0] ODD_HALVES       = 17'h00204;

  typedef logic [PER_W-1:0] sbtw_per_t;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_NREQ,
    ST_NORMAL,
    ST_LOWPOWER,
    ST_FLASH
  } sbtw_mode_t;

  function automatic sbtw_per_t sbtw_dbl(input logic [9:0] base, input logic [2:0] sh);
    return sbtw_per_t'(base) << sh;
  endfunction

endpackage

// >>> hdl/sbtw_link_if.sv
/*
  Carrier between the link-side receiver and the core.
  Word is written on the same link clock edge that flips tgl; core samples after sync.
*/
`timescale 1ns/1ps
interface sbtw_link_if;
  logic [15:0] word;
  logic        tgl;
  modport rx   (output word, output tgl);
  modport core (input word, input tgl);
endinterface

// >>> hdl/sbtw_spi_rx.sv
/*
  Serial frame receiver running on the link clock.
  Assumes the link clock only runs while chip select is low, mode 0 sampling.
*/
`timescale 1ns/1ps
module sbtw_spi_rx
  import sbtw_pkg::*;
(
  input  wire logic   sclk_i,
  input  wire logic   rst_n_i,
  input  wire logic   cs_n_i,
  input  wire logic   mosi_i,
  output logic        miso_o,
  output logic        miso_oe_n_o,
  sbtw_link_if.rx     link
);

  typedef struct packed {
    logic [4:0]  cnt;
    logic [15:0] sh;
  } sbtw_frm_t;

  typedef struct packed {
    logic [15:0] word;
    logic        tgl;
  } sbtw_hold_t;

  sbtw_frm_t  f;
  sbtw_frm_t  next_f;
  sbtw_hold_t h;
  sbtw_hold_t next_h;
  logic       frm_rst_n;

  // Frame state is cleared by chip select itself, no link edge needed
  assign frm_rst_n = rst_n_i & ~cs_n_i;

  always_comb
  begin
    next_f    = f;
    next_h    = h;
    next_f.sh = {f.sh[14:0], mosi_i};
    if (f.cnt != 5'(FRAME_BITS))
    begin
      next_f.cnt = f.cnt + 5'h1;
    end
    // Extra bits beyond sixteen are ignored
    if (f.cnt == 5'(FRAME_BITS - 1))
    begin
      next_h.word = next_f.sh;
      next_h.tgl  = ~h.tgl;
    end
  end

  always_ff @(posedge sclk_i or negedge frm_rst_n)
  begin
    if (!frm_rst_n)
      f <= '0;
    else
      f <= next_f;
  end

  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      h <= '0;
    else
      h <= next_h;
  end

  // Previous frame is echoed back, MSB first
  assign miso_o      = (f.cnt < 5'(FRAME_BITS)) ? h.word[4'(15 - f.cnt)] : 1'b0;
  assign miso_oe_n_o = cs_n_i;
  assign link.word   = h.word;
  assign link.tgl    = h.tgl;

endmodule

// >>> hdl/sbtw_wd_timer.sv
/*
  Watchdog period counter in half-millisecond ticks.
  Assumes period_i is stable or restart_i is pulsed whenever it changes.
*/
`timescale 1ns/1ps
module sbtw_wd_timer
  import sbtw_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       restart_i,
  input  wire sbtw_per_t  period_i,
  output logic            expire_o
);

  localparam int PW = $clog2(TICK_CYC_P);

  if (TICK_CYC_P < 2)
  begin : g_bad_tick
    $error("TICK_CYC_P must be at least 2");
  end

  typedef struct packed {
    logic [PW-1:0] pre;
    sbtw_per_t     halves;
    logic          exp;
  } sbtw_wdt_t;

  sbtw_wdt_t r;
  sbtw_wdt_t next_r;

  always_comb
  begin
    next_r     = r;
    next_r.exp = 1'b0;
    if (restart_i)
    begin
      next_r.pre    = '0;
      next_r.halves = '0;
    end
    else if (r.pre == PW'(TICK_CYC_P - 1))
    begin
      next_r.pre = '0;
      if (r.halves + sbtw_per_t'(1) >= period_i)
      begin
        next_r.halves = '0;
        next_r.exp    = 1'b1;
      end
      else
      begin
        next_r.halves = r.halves + sbtw_per_t'(1);
      end
    end
    else
    begin
      next_r.pre = r.pre + PW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign expire_o = r.exp;

  property p_restart_clears;
    @(posedge clk_i) disable iff (!rst_n_i)
    restart_i |=> (r.halves == '0) && (r.pre == '0) && !expire_o;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("watchdog count not cleared by restart");

endmodule

// >>> test/sbtw_host_model.sv
/*
  Host side of the serial link: sends 16-bit write frames, MSB first.
  Runs on its own delays, so its 30 ns link clock has no phase tie to the core clock.
*/
`timescale 1ns/1ps
module sbtw_host_model
  import sbtw_pkg::*;
(
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  logic [15:0] echo;

  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Word layout: command, address, parity, data
  task automatic send(input logic [15:0] w);
    cs_n_o = 1'b0;
    #7;
    for (int i = FRAME_BITS - 1; i >= 0; i--)
    begin
      mosi_o = w[i];
      // Sampled just before the rising edge, as a mode 0 master would
      #15 echo[i] = miso_i;
      sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
    end
    #5 cs_n_o = 1'b1;
    // Released line must not keep looking valid
    mosi_o = ~mosi_o;
  endtask
endmodule

// >>> test/testbench.sv
/*
  Self-checking bench for the timing and watchdog core.
  Assumes short tick and hold parameters; the host model drives the link.
*/
`timescale 1ns/1ps
module testbench;
  import sbtw_pkg::*;
  localparam int TICK = 4;
  localparam int HOLD = 8;
  logic       clk_i, rst_n_i, sclk, cs_n, mosi, miso, miso_oe_n;
  logic       parity_en, enter_nreq, enter_lp, enter_flash, wd_rst_n, frame_err;
  logic [2:0] mode, em;
  logic [7:0] r1, r2, r3, t1, t2, t3, d;
  logic [4:0] a;
  sbtw_per_t  oc, wdp, cs_per, ci_per, forced_wakeup_period;
  int         fails = 0;
  int         checks_done = 0;
  int         errs = 0;
  int         lows = 0;
  int         n;
  logic [15:0] last_w = 16'h0000;

  sbtw_top #(.TICK_CYC_P(TICK), .RST_HOLD_CYC_P(HOLD)) sbtw_top_inst (
    .clk_i                    (clk_i),
    .rst_n_i                  (rst_n_i),
    .sclk_i                   (sclk),
    .cs_n_i                   (cs_n),
    .mosi_i                   (mosi),
    .miso_o                   (miso),
    .miso_oe_n_o              (miso_oe_n),
    .parity_en_i              (parity_en),
    .enter_nreq_i             (enter_nreq),
    .enter_lowpower_i         (enter_lp),
    .enter_flash_i            (enter_flash),
    .mode_o                   (mode),
    .wd_reset_n_o             (wd_rst_n),
    .frame_err_o              (frame_err),
    .oc_window_o              (oc),
    .wd_period_o              (wdp),
    .cyc_sense_o              (cs_per),
    .cyc_int_o                (ci_per),
    .fwu_o                    (forced_wakeup_period),
    .first_timing_register_o  (r1),
    .second_timing_register_o (r2),
    .third_timing_register_o  (r3)
  );

  sbtw_host_model sbtw_host_model_inst (
    .sclk_o (sclk),
    .cs_n_o (cs_n),
    .mosi_o (mosi),
    .miso_i (miso)
  );

  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  // Counted on the falling edge, opposite the launching edge, so registered outputs have settled
  always @(negedge clk_i)
  begin
    if (frame_err === 1'b1)
      errs <= errs + 1;
    if (wd_rst_n === 1'b0)
      lows <= lows + 1;
  end

  task automatic check(input sbtw_per_t seen, input sbtw_per_t exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic sbtw_per_t dbl(input int base, input logic [2:0] sh);
    return sbtw_per_t'(base) << sh;
  endfunction

  function automatic sbtw_per_t exp_wd(input logic [2:0] m);
    if (m == 3'h3)
      return dbl(t3[7] ? 32 : 24, t3[6:4]);
    if (m == 3'h4)
      return dbl(t3[7] ? 512 : 96, t3[6:4]);
    return dbl(5 + int'(t1[4:3]), t1[2:0]);
  endfunction

  // Even parity over the whole frame when checking is on
  function automatic logic [15:0] frm(input logic [4:0] ad, input logic [7:0] v, input logic p);
    logic [15:0] w;
    w = {CMD_WRITE, ad, 1'b0, v};
    w[8] = p & ^w;
    return w;
  endfunction

  task automatic chk_all();
    check(sbtw_per_t'(mode), sbtw_per_t'(em));
    check(sbtw_per_t'(r1), sbtw_per_t'(t1));
    check(sbtw_per_t'(r2), sbtw_per_t'(t2));
    check(sbtw_per_t'(r3), sbtw_per_t'(t3));
    check(oc, dbl(t1[7] ? 8 : 6, {1'b0, t1[6:5]}));
    check(wdp, exp_wd(em));
    check(cs_per, dbl(t2[7] ? 8 : 6, t2[6:4]));
    check(ci_per, t2[3:0] == 4'hd ? ODD_HALVES : dbl(t2[3] ? 16 : 12, t2[2:0]));
    check(forced_wakeup_period, t3[3:0] == 4'ha ? ODD_HALVES : dbl(t3[3] ? 128 : 96, t3[2:0]));
  endtask

  task automatic xfer(input logic [15:0] w, input int exp_err);
    int e0;
    e0 = errs;
    sbtw_host_model_inst.send(w);
    // Link echoes the previous whole frame while the next one shifts in
    check(sbtw_per_t'(sbtw_host_model_inst.echo), sbtw_per_t'(last_w));
    last_w = w;
    repeat (8) @(negedge clk_i);
    check(sbtw_per_t'(errs - e0), sbtw_per_t'(exp_err));
  endtask

  task automatic wr(input logic [4:0] ad, input logic [7:0] v);
    xfer(frm(ad, v, parity_en), 0);
    if (ad == ADDR_TIM1)
      t1 = v;
    else if (ad == ADDR_TIM2)
      t2 = v;
    else
      t3 = v;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask

  initial
  begin
    void'($urandom(49924));
    rst_n_i = 1'b0;
    parity_en = 1'b0;
    enter_nreq = 1'b0;
    enter_lp = 1'b0;
    enter_flash = 1'b0;
    t1 = TIM1_RST;
    t2 = TIM2_RST;
    t3 = TIM3_RST;
    em = 3'h0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk_all();
    check(sbtw_per_t'(miso_oe_n), 17'h00001);
    xfer(REFRESH_CMD, 0);
    em = 3'h2;
    chk_all();
    xfer({2'h0, ADDR_TIM1, 1'b0, 8'h00}, 0);
    chk_all();
    for (int i = 0; i < 24; i++)
    begin
      a = ADDR_TIM1 + 5'(i % 3);
      d = 8'($urandom);
      if (i == 0)
        d[7:5] = 3'h7;
      if (i == 4)
        d[7:4] = 4'hf;
      if (i == 1)
        d[3:0] = 4'hd;
      if (i == 2)
        d[3:0] = 4'ha;
      // Keep the normal period well above the spacing of refreshes
      if (a == ADDR_TIM1)
        d[2] = 1'b1;
      wr(a, d);
      xfer(REFRESH_CMD, 0);
      chk_all();
    end
    wr(ADDR_TIM3, {4'h7, t3[3:0]});
    pulse(enter_lp);
    em = 3'h3;
    chk_all();
    wr(ADDR_TIM3, {4'hf, t3[3:0]});
    pulse(enter_flash);
    em = 3'h4;
    chk_all();
    pulse(enter_nreq);
    em = 3'h1;
    chk_all();
    xfer(REFRESH_CMD, 0);
    em = 3'h2;
    chk_all();
    parity_en = 1'b1;
    @(negedge clk_i);
    wr(ADDR_TIM2, 8'($urandom));
    chk_all();
    xfer(frm(ADDR_TIM2, ~t2, 1'b1) ^ 16'h0100, 1);
    chk_all();
    parity_en = 1'b0;
    xfer(frm(ADDR_TIM3, 8'h5a, 1'b0) | 16'h0100, 1);
    xfer(REFRESH_CMD | 16'h0001, 1);
    chk_all();
    check(sbtw_per_t'(lows), 17'h00000);
    wr(ADDR_TIM1, 8'h00);
    for (n = 0; n < 500 && !(wd_rst_n === 1'b1 && lows > 0); n++)
      @(negedge clk_i);
    if (n == 500)
      fails++;
    else
    begin
      check(sbtw_per_t'(lows), sbtw_per_t'(HOLD));
      em = 3'h1;
      chk_all();
    end
    finish_test();
  end
endmodule
